// ### rtl/mdm_motor_io.sv
// Contract
// (RULE_01) exactly one of forward or reverse active runs motor that way
// (RULE_02) forward and reverse both active stops motor instantly, no ramp
// (RULE_03) two data-select inputs pick entry; both inactive selects entry 0
// (RULE_04) select low is bit 0, select high is bit 1, entries 0 to 3
// (RULE_05) four entries, each speed, acceleration and deceleration time
// (RULE_06) fault-clear input clears the active alarm after a trip
// (RULE_07) external fault is normally closed; open trips alarm, instant stop, code
// (RULE_08) hold-release input cancels standstill holding torque
// (RULE_09) three input terminals mapped to functions; defaults fwd, rev, select low
// (RULE_10) a function mapped to several terminals is the OR of them
// (RULE_11) two output terminals mapped; defaults tachometer and fault
// (RULE_12) fault output on in normal operation, off while alarm active
// (RULE_13) tachometer gives 30 pulses per revolution, each 0.2 ms wide
// (RULE_14) overload output, normally closed, opens above warning level or overload alarm
// (RULE_15) running output on while motor operates
// (RULE_16) speed-reached output on when speed within band of command
// (RULE_17) attainment band settable 0 to 400 r/min, default 200
// (RULE_18) warning output follows warning condition, motor keeps running
// (RULE_19) speed monitor scaled by reduction or increasing ratio
// (RULE_20) load view 40 to 200 percent in 1 percent steps, low-load flag below
// (RULE_21) holding indicator replaces load value while position-keeping enabled
// (RULE_22) a view shows the selected entry number
// (RULE_23) alarm view shows code, alarm reset and history clear
// (RULE_24) warning view shows code, warning history inspect and clear
// (RULE_25) io view lights one segment per active input and output
// (RULE_26) speed view after power-up, settable initial view
// (RULE_27) controller keeps forward and reverse exclusive except to stop
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module mdm_motor_io
    import mdm_pkg::*;
#(
    parameter mdm_view_e INIT_VIEW = VIEW_SPEED
)(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                input_terminal_0,
    input  wire logic                input_terminal_1,
    input  wire logic                input_terminal_2,
    output logic                     output_terminal_0,
    output logic                     output_terminal_1,
    input  wire logic                tach_edge_in,
    input  wire logic [SPD_W-1:0]    speed_rpm_in,
    input  wire logic [7:0]          load_pct_in,
    input  wire logic                overload_alarm_in,
    output logic                     drive_fwd,
    output logic                     drive_rev,
    output logic                     drive_instant_stop,
    output logic                     drive_hold,
    output logic      [SPD_W-1:0]    drive_speed,
    output logic      [TIME_W-1:0]   drive_acc,
    output logic      [TIME_W-1:0]   drive_dec,
    output logic      [5:0]          disp_view,
    output logic      [15:0]         disp_value,
    output logic                     disp_low_load,
    output logic                     disp_hold,
    output logic                     disp_alarm_blink
);

    if (TACH_CYC >= (1 << TACH_CNT_W) || TACH_CYC < 1) begin : g_chk
        $error("tachometer pulse count does not fit its counter");
    end

    // ------------------------------------------------------------
    // terminal synchronisers
    // ------------------------------------------------------------
    logic [2:0] term_s1_q;
    logic [2:0] term_s2_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            term_s1_q <= 3'h0;
            term_s2_q <= 3'h0;
        end else begin
            term_s1_q <= {input_terminal_2, input_terminal_1, input_terminal_0};
            term_s2_q <= term_s1_q;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0]        ctrl_q;
    logic [8:0]         band_q;
    logic [7:0]         olw_q;
    logic [16:0]        ratio_q;
    mdm_view_e          view_q;
    logic [27:0]        entry_q [4];
    logic [7:0]         alarm_q;
    logic [7:0]         alm_hist_q;
    logic [7:0]         wng_hist_q;
    logic               clr_prev_q;
    logic [TACH_CNT_W-1:0] tach_cnt_q;
    logic [1:0]         out_term_q;

    wire acc_en   = psel && penable && pready;
    wire wr_en    = acc_en && pwrite;
    wire wr_ctrl  = wr_en && paddr == A_CTRL;
    wire wr_band  = wr_en && paddr == A_BAND;
    wire wr_olw   = wr_en && paddr == A_OLWARN;
    wire wr_ratio = wr_en && paddr == A_RATIO;
    wire wr_cmd   = wr_en && paddr == A_CMD;
    wire wr_view  = wr_en && paddr == A_VIEW;

    // ------------------------------------------------------------
    // input function decode
    // ------------------------------------------------------------
    logic [NF_IN-1:0] func;
    logic [NF_IN-1:0] func_mapped;

    for (genvar f = 0; f < NF_IN; f++) begin : g_func
        logic [2:0] hit;
        for (genvar t = 0; t < 3; t++) begin : g_term
            assign hit[t] = ctrl_q[IN_MAP_LSB + MAP_STEP*t +: MAP_W] == MAP_W'(f);
        end
        assign func[f]        = |(hit & term_s2_q);  // see (RULE_09) (RULE_10)
        assign func_mapped[f] = |hit;
    end

    wire        run_fwd  = func[F_FWD];
    wire        run_rev  = func[F_REV];
    wire [1:0]  sel      = {func[F_SEL_HI], func[F_SEL_LO]};  // see (RULE_03) (RULE_04)
    wire [27:0] entry    = entry_q[sel];  // see (RULE_05)
    wire        hold_en  = ctrl_q[HOLD_EN_BIT];
    wire        clr_rise = func[F_CLR] && !clr_prev_q;

    // ------------------------------------------------------------
    // alarm and warning
    // ------------------------------------------------------------
    // an unmapped external-fault function cannot trip the drive
    wire ext_trip = func_mapped[F_EXT] && !func[F_EXT];  // see (RULE_07)
    wire [7:0] trip_code = ext_trip ? ALM_EXT :
                           overload_alarm_in ? ALM_OVL : ALM_NONE;
    wire alm_clr  = clr_rise || (wr_cmd && pwdata[CMD_ALM_RST]);  // see (RULE_06) (RULE_23)
    wire alm_act  = alarm_q != ALM_NONE;
    wire ovl_warn = load_pct_in > olw_q;
    wire [7:0] warn_code = ovl_warn ? WNG_OVL : ALM_NONE;  // see (RULE_18)

    // a trip still present wins over a clear, so the alarm stays set and keeps its code
    wire [7:0] alarm_d = (trip_code != ALM_NONE) ? (alm_act ? alarm_q : trip_code) :
                         alm_clr ? ALM_NONE : alarm_q;
    wire [7:0] alm_hist_d = (trip_code != ALM_NONE) ? trip_code :
                            (wr_cmd && pwdata[CMD_ALM_CLR]) ? ALM_NONE : alm_hist_q;
    wire [7:0] wng_hist_d = ovl_warn ? warn_code :
                            (wr_cmd && pwdata[CMD_WNG_CLR]) ? ALM_NONE : wng_hist_q;  // see (RULE_24)

    // ------------------------------------------------------------
    // output functions
    // ------------------------------------------------------------
    wire [SPD_W-1:0] cmd_spd = entry[SPD_W-1:0];
    wire [SPD_W-1:0] spd_err = speed_rpm_in >= cmd_spd ? speed_rpm_in - cmd_spd
                                                       : cmd_spd - speed_rpm_in;
    wire running = speed_rpm_in != '0;
    wire [NF_OUT-1:0] ofunc;

    assign ofunc[0]       = 1'b0;
    assign ofunc[O_FAULT] = !alm_act;  // see (RULE_12)
    assign ofunc[O_TACH]  = tach_cnt_q != '0;
    assign ofunc[O_OVL]   = !(ovl_warn || alarm_q == ALM_OVL);  // see (RULE_14)
    assign ofunc[O_RUN]   = running;  // see (RULE_15)
    assign ofunc[O_REACH] = (drive_fwd || drive_rev) && {3'h0, spd_err} <= band_q;  // see (RULE_16)
    assign ofunc[O_WARN]  = ovl_warn;  // see (RULE_18)
    assign ofunc[NF_OUT-1] = 1'b0;

    for (genvar o = 0; o < 2; o++) begin : g_out
        always_ff @(posedge clk) begin
            if (!resetn) begin
                out_term_q[o] <= 1'b0;
            end else begin
                out_term_q[o] <= ofunc[ctrl_q[OUT_MAP_LSB + MAP_STEP*o +: MAP_W]];  // see (RULE_11)
            end
        end
    end

    assign output_terminal_0 = out_term_q[0];
    assign output_terminal_1 = out_term_q[1];

    // ------------------------------------------------------------
    // monitor values
    // ------------------------------------------------------------
    // ratio below unity is meaningless, treated as unity
    wire [31:0] ratio_eff = (ratio_q[15:0] < RATIO_UNITY) ? {16'h0, RATIO_UNITY}
                                                          : {16'h0, ratio_q[15:0]};
    wire [31:0] spd_ext   = {{(32-SPD_W){1'b0}}, speed_rpm_in};
    wire [31:0] spd_red   = (spd_ext * {16'h0, RATIO_UNITY}) / ratio_eff;
    wire [31:0] spd_inc   = (spd_ext * ratio_eff) / {16'h0, RATIO_UNITY};
    wire [31:0] spd_show  = ratio_q[RATIO_INC_BIT] ? spd_inc : spd_red;  // see (RULE_19)
    wire [7:0]  load_show = load_pct_in > LOAD_MAX ? LOAD_MAX : load_pct_in;  // see (RULE_20)
    wire [4:0]  io_bits   = {out_term_q, term_s2_q};  // see (RULE_25)

    logic [15:0] mon_val;
    always_comb begin
        mon_val = 16'h0000;
        unique case (view_q)
            VIEW_SPEED: mon_val = spd_show[15:0];
            VIEW_LOAD:  mon_val = {8'h0, load_show};
            VIEW_DATA:  mon_val = {14'h0, sel};  // see (RULE_22)
            VIEW_ALARM: mon_val = {8'h0, alarm_q};  // see (RULE_23)
            VIEW_WARN:  mon_val = {8'h0, warn_code};  // see (RULE_24)
            VIEW_IO:    mon_val = {11'h0, io_bits};
        endcase
    end

    wire view_ok = pwdata[5:0] inside {VIEW_SPEED, VIEW_LOAD, VIEW_DATA,
                                      VIEW_ALARM, VIEW_WARN, VIEW_IO};

    // ------------------------------------------------------------
    // apb read decode
    // ------------------------------------------------------------
    wire ent_hit = paddr[7:4] == A_ENTRY0[7:4];
    wire [31:0] status_w = {3'h0, io_bits, 6'h0, sel, warn_code, alarm_q};
    wire [31:0] hist_w   = {16'h0, wng_hist_q, alm_hist_q};
    wire rd_hit = paddr inside {A_CTRL, A_BAND, A_OLWARN, A_RATIO, A_STATUS,
                                A_MONITOR, A_CMD, A_HIST, A_VIEW} || ent_hit;
    wire [31:0] rd_data =
        paddr == A_CTRL    ? ctrl_q :
        paddr == A_BAND    ? {23'h0, band_q} :
        paddr == A_OLWARN  ? {24'h0, olw_q} :
        paddr == A_RATIO   ? {15'h0, ratio_q} :
        paddr == A_STATUS  ? status_w :
        paddr == A_MONITOR ? {disp_low_load, disp_hold, 8'h0, disp_view, disp_value} :
        paddr == A_HIST    ? hist_w :
        paddr == A_VIEW    ? {26'h0, view_q} :
        ent_hit            ? {4'h0, entry_q[paddr[3:2]]} : 32'h0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            // no wait state: answer registered in the setup cycle, ready in the first access cycle
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q  <= CTRL_RST;
            band_q  <= BAND_RST;
            olw_q   <= OLWARN_RST;
            ratio_q <= {1'b0, RATIO_UNITY};
            view_q  <= INIT_VIEW;  // see (RULE_26)
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata;
            if (wr_band) band_q <= pwdata[8:0] > BAND_MAX ? BAND_MAX : pwdata[8:0];  // see (RULE_17)
            if (wr_olw) olw_q <= pwdata[7:0];
            if (wr_ratio) ratio_q <= pwdata[16:0];
            if (wr_view && view_ok) view_q <= mdm_view_e'(pwdata[5:0]);
        end
    end

    for (genvar e = 0; e < 4; e++) begin : g_entry
        wire wr_ent = wr_en && ent_hit && paddr[3:2] == 2'(e);
        always_ff @(posedge clk) begin
            if (!resetn) begin
                entry_q[e] <= ENTRY_RST;
            end else if (wr_ent) begin
                entry_q[e] <= pwdata[27:0];
            end
        end
    end

    // ------------------------------------------------------------
    // alarm state and tachometer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alarm_q    <= ALM_NONE;
            alm_hist_q <= ALM_NONE;
            wng_hist_q <= ALM_NONE;
            clr_prev_q <= 1'b0;
            tach_cnt_q <= '0;
        end else begin
            alarm_q    <= alarm_d;
            alm_hist_q <= alm_hist_d;
            wng_hist_q <= wng_hist_d;
            clr_prev_q <= func[F_CLR];
            // each of the 30 per-rev shaft edges restarts a fixed-width pulse
            if (tach_edge_in) begin
                tach_cnt_q <= TACH_CNT_W'(TACH_CYC);  // see (RULE_13)
            end else if (tach_cnt_q != '0) begin
                tach_cnt_q <= tach_cnt_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // drive commands and display
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_fwd          <= 1'b0;
            drive_rev          <= 1'b0;
            drive_instant_stop <= 1'b0;
            drive_hold         <= 1'b0;
            drive_speed        <= '0;
            drive_acc          <= '0;
            drive_dec          <= '0;
        end else begin
            drive_fwd          <= run_fwd && !run_rev && alarm_d == ALM_NONE;  // see (RULE_01)
            drive_rev          <= run_rev && !run_fwd && alarm_d == ALM_NONE;  // see (RULE_01)
            drive_instant_stop <= (run_fwd && run_rev) || alarm_d != ALM_NONE;  // see (RULE_02) (RULE_07)
            drive_hold         <= hold_en && !func[F_HREL];  // see (RULE_08)
            drive_speed        <= cmd_spd;
            drive_acc          <= entry[ACC_LSB +: TIME_W];
            drive_dec          <= entry[DEC_LSB +: TIME_W];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            disp_view        <= 6'h00;
            disp_value       <= 16'h0000;
            disp_low_load    <= 1'b0;
            disp_hold        <= 1'b0;
            disp_alarm_blink <= 1'b0;
        end else begin
            disp_view        <= view_q;
            disp_value       <= mon_val;
            disp_low_load    <= view_q == VIEW_LOAD && !hold_en && load_pct_in < LOAD_MIN;  // see (RULE_20)
            disp_hold        <= view_q == VIEW_LOAD && hold_en;  // see (RULE_21)
            disp_alarm_blink <= alm_act;
        end
    end

endmodule // mdm_motor_io

`default_nettype wire

// ### rtl/mdm_pkg.sv
package mdm_pkg;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  A_CTRL      = 8'h00;
    localparam logic [7:0]  A_BAND      = 8'h04;
    localparam logic [7:0]  A_OLWARN    = 8'h08;
    localparam logic [7:0]  A_RATIO     = 8'h0C;
    localparam logic [7:0]  A_STATUS    = 8'h10;
    localparam logic [7:0]  A_MONITOR   = 8'h14;
    localparam logic [7:0]  A_CMD       = 8'h18;
    localparam logic [7:0]  A_HIST      = 8'h1C;
    localparam logic [7:0]  A_VIEW      = 8'h20;
    localparam logic [7:0]  A_ENTRY0    = 8'h30;

    // ------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------
    localparam int          MAP_W       = 3;
    localparam int          MAP_STEP    = 4;
    localparam int          IN_MAP_LSB  = 0;
    localparam int          OUT_MAP_LSB = 12;
    localparam int          HOLD_EN_BIT = 20;
    localparam logic [31:0] CTRL_RST    = 32'h0001_2321;
    localparam logic [8:0]  BAND_RST    = 9'h0C8;
    localparam logic [8:0]  BAND_MAX    = 9'h190;
    localparam logic [7:0]  OLWARN_RST  = 8'h78;
    localparam logic [15:0] RATIO_UNITY = 16'h0064;
    localparam int          RATIO_INC_BIT = 16;
    localparam int          SPD_W       = 12;
    localparam int          TIME_W      = 8;
    localparam int          ACC_LSB     = 12;
    localparam int          DEC_LSB     = 20;
    localparam logic [27:0] ENTRY_RST   = 28'h0505_032;
    localparam int          CMD_ALM_RST = 0;
    localparam int          CMD_ALM_CLR = 1;
    localparam int          CMD_WNG_CLR = 2;

    // ------------------------------------------------------------
    // input and output function codes
    // ------------------------------------------------------------
    localparam int          NF_IN       = 8;
    localparam int          F_FWD       = 1;
    localparam int          F_REV       = 2;
    localparam int          F_SEL_LO    = 3;
    localparam int          F_SEL_HI    = 4;
    localparam int          F_CLR       = 5;
    localparam int          F_EXT       = 6;
    localparam int          F_HREL      = 7;
    localparam int          NF_OUT      = 8;
    localparam int          O_FAULT     = 1;
    localparam int          O_TACH      = 2;
    localparam int          O_OVL       = 3;
    localparam int          O_RUN       = 4;
    localparam int          O_REACH     = 5;
    localparam int          O_WARN      = 6;

    // ------------------------------------------------------------
    // alarm / warning codes and display limits
    // ------------------------------------------------------------
    localparam logic [7:0]  ALM_NONE    = 8'h00;
    localparam logic [7:0]  ALM_OVL     = 8'h30;
    localparam logic [7:0]  ALM_EXT     = 8'h6E;
    localparam logic [7:0]  WNG_OVL     = 8'h30;
    localparam logic [7:0]  LOAD_MIN    = 8'h28;
    localparam logic [7:0]  LOAD_MAX    = 8'hC8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          TACH_PULSE_NS = 200000;
    localparam int          TACH_CYC    = (TACH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TACH_CNT_W  = 12;

    typedef enum logic [5:0] {
        VIEW_SPEED = 6'b000001,
        VIEW_LOAD  = 6'b000010,
        VIEW_DATA  = 6'b000100,
        VIEW_ALARM = 6'b001000,
        VIEW_WARN  = 6'b010000,
        VIEW_IO    = 6'b100000
    } mdm_view_e;

endpackage

// ### tb/mdm_motor_io_props.sv
`timescale 1ns/10ps
`default_nettype none

module mdm_motor_io_props
    import mdm_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        drive_fwd,
    input wire logic        drive_rev,
    input wire logic        drive_instant_stop,
    input wire logic [5:0]  disp_view,
    input wire logic        disp_low_load,
    input wire logic        disp_hold
);
    // ------------------------------------------------------------
    // port relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_DIR_EXCL: assert property (!(drive_fwd && drive_rev))
        else $error("forward and reverse commanded together");
    AST_STOP_NO_RUN: assert property (drive_instant_stop |-> !drive_fwd && !drive_rev)
        else $error("run command during instant stop");
    AST_HOLD_FLAG: assert property (disp_hold |-> disp_view == VIEW_LOAD && !disp_low_load)
        else $error("hold flag outside load view or with low flag");
    AST_LOW_FLAG: assert property (disp_low_load |-> disp_view == VIEW_LOAD)
        else $error("low load flag outside load view");
    AST_VIEW_ONEHOT: assert property ($past(resetn) |-> $onehot(disp_view))
        else $error("view not one-hot");
    AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel) && !$past(penable))
        else $error("ready without setup");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");

    COV_STOP: cover property (drive_instant_stop);
    COV_ERR: cover property (pslverr);
    COV_HOLD: cover property (disp_hold);
endmodule // mdm_motor_io_props

`default_nettype wire

// ### tb/mdm_plc_model.sv
`timescale 1ns/10ps
`default_nettype none

module mdm_plc_model (
    input  wire logic       clk,
    input  wire logic [2:0] want,
    output logic            term_0,
    output logic            term_1,
    output logic            term_2
);
    // ------------------------------------------------------------
    // controller output scan
    // ------------------------------------------------------------
    // levels change only after an edge, like a real scan cycle;
    // both run terminals together only when the bench asks for a stop
    logic [2:0] scan_q = 3'h0;

    always @(posedge clk) begin
        scan_q <= want;
    end

    assign term_0 = scan_q[0];
    assign term_1 = scan_q[1];
    assign term_2 = scan_q[2];
endmodule // mdm_plc_model

`default_nettype wire

// ### tb/motor_driver_io_and_monitor_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module motor_driver_io_and_monitor_tb_top;
    import mdm_pkg::*;
    logic             clk, resetn, psel, penable, pwrite, pready, pslverr, er, tach;
    logic             t0, t1, t2, y0, y1, dfwd, drev, dstop;
    logic [7:0]       paddr, load;
    logic [31:0]      pwdata, prdata, rd;
    logic [2:0]       want;
    logic [SPD_W-1:0] spd, sr;
    int               error_cnt, compares, n;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    mdm_motor_io uut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_terminal_0(t0), .input_terminal_1(t1), .input_terminal_2(t2), .output_terminal_0(y0),
        .output_terminal_1(y1), .tach_edge_in(tach), .speed_rpm_in(sr), .load_pct_in(load),
        .overload_alarm_in(1'b0), .drive_fwd(dfwd), .drive_rev(drev), .drive_instant_stop(dstop),
        .drive_hold(), .drive_speed(spd), .drive_acc(), .drive_dec(), .disp_view(), .disp_value(),
        .disp_low_load(), .disp_hold(), .disp_alarm_blink());
    mdm_plc_model plc (.clk(clk), .want(want), .term_0(t0), .term_1(t1), .term_2(t2));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude;
        if (error_cnt == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // values read at the edge are those settled before it
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // terminals need sync plus output register: six edges is ample
    task automatic drive(input logic [2:0] w);
        @(posedge clk);
        want <= w;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, psel, penable, pwrite, tach, er} = 6'h00;
        {paddr, pwdata, want, load, sr, error_cnt, compares} = '0;
        load = 8'h50;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        apb(1'b0, A_CTRL, 32'h0);
        chk("ctrl", rd, CTRL_RST);
        apb(1'b0, A_BAND, 32'h0);
        chk("band", rd, {23'h0, BAND_RST});
        apb(1'b1, A_BAND, 32'h0000_01FF);
        apb(1'b0, A_BAND, 32'h0);
        chk("band clamp", rd, {23'h0, BAND_MAX});
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        apb(1'b0, A_VIEW, 32'h0);
        chk("view", rd, {26'h0, VIEW_SPEED});
        drive(3'b001);
        chk("fwd", {29'h0, dfwd, drev, dstop}, 32'h4);
        drive(3'b010);
        chk("rev", {29'h0, dfwd, drev, dstop}, 32'h2);
        drive(3'b011);
        chk("both", {29'h0, dfwd, drev, dstop}, 32'h1);
        drive(3'b100);
        apb(1'b0, A_STATUS, 32'h0);
        chk("sel lo", {30'h0, rd[17:16]}, 32'h1);
        apb(1'b1, A_ENTRY0 + 8'h0C, 32'h0030_2123);
        apb(1'b1, A_CTRL, 32'h0001_2341);
        drive(3'b110);
        apb(1'b0, A_STATUS, 32'h0);
        chk("sel 3", {30'h0, rd[17:16]}, 32'h3);
        chk("speed 3", {20'h0, spd}, 32'h0000_0123);
        drive(3'b000);
        chk("speed 0", {20'h0, spd}, {20'h0, ENTRY_RST[11:0]});
        apb(1'b1, A_CTRL, 32'h0001_2311);
        drive(3'b010);
        chk("or map", {31'h0, dfwd}, 32'h1);
        apb(1'b1, A_CTRL, 32'h0001_2651);
        drive(3'b001);
        apb(1'b0, A_STATUS, 32'h0);
        chk("ext code", {24'h0, rd[7:0]}, {24'h0, ALM_EXT});
        chk("ext stop", {30'h0, dfwd, dstop}, 32'h1);
        chk("fault out", {31'h0, y1}, 32'h0);
        drive(3'b101);
        drive(3'b111);
        apb(1'b0, A_STATUS, 32'h0);
        chk("cleared", {24'h0, rd[7:0]}, {24'h0, ALM_NONE});
        chk("fault ok", {30'h0, y1, dfwd}, 32'h3);
        apb(1'b1, A_VIEW, {26'h0, VIEW_LOAD});
        load <= 8'h10;
        apb(1'b0, A_MONITOR, 32'h0);
        chk("low load", {30'h0, rd[31:30]}, 32'h2);
        apb(1'b1, A_CTRL, 32'h0011_2321);
        apb(1'b0, A_MONITOR, 32'h0);
        chk("hold", {30'h0, rd[31:30]}, 32'h1);
        apb(1'b1, A_CTRL, 32'h0014_2321);
        sr <= 12'h0C8;
        load <= 8'h80;
        apb(1'b0, A_STATUS, 32'h0);
        chk("running", {31'h0, rd[28]}, 32'h1);
        chk("warn", {24'h0, rd[15:8]}, {24'h0, WNG_OVL});
        @(posedge clk);
        tach <= 1'b1;
        @(posedge clk);
        tach <= 1'b0;
        for (n = 0; n < 10 && y0 !== 1'b1; n++)
            @(negedge clk);
        for (n = 0; n < 3000 && y0 === 1'b1; n++)
            @(negedge clk);
        chk("tach width", 32'(n), 32'(TACH_CYC));
        conclude();
    end
endmodule // motor_driver_io_and_monitor_tb_top

bind mdm_motor_io mdm_motor_io_props u_props (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .drive_fwd(drive_fwd), .drive_rev(drive_rev),
    .drive_instant_stop(drive_instant_stop), .disp_view(disp_view), .disp_low_load(disp_low_load),
    .disp_hold(disp_hold));

`default_nettype wire
